// [include/cdr_ctrl_pkg.sv]
package cdr_ctrl_pkg;

  // Register offsets on the serial management bus
  localparam logic [7:0] STATUS_A_OFS = 8'h06;
  localparam logic [7:0] CONTROL_A_OFS = 8'h08;
  localparam logic [7:0] MAIN_CONTROL_B_OFS = 8'h09;
  localparam logic [7:0] REF_CLOCK_POWER_OFS = 8'h0a;
  localparam logic [7:0] REF_LOCK_SETUP_OFS = 8'h0f;
  localparam logic [7:0] LOOP_CONTROL_A_OFS = 8'h10;
  localparam logic [7:0] LOOP_CONTROL_D_OFS = 8'h13;

  // Writable bit masks; everything else is reserved
  localparam logic [7:0] CONTROL_A_MASK = 8'h70;
  localparam logic [7:0] MAIN_CONTROL_B_MASK = 8'hfc;
  localparam logic [7:0] REF_CLOCK_POWER_MASK = 8'h04;
  localparam logic [7:0] REF_LOCK_SETUP_MASK = 8'h7f;
  localparam logic [7:0] LOOP_CONTROL_A_MASK = 8'h1f;
  localparam logic [7:0] LOOP_CONTROL_D_MASK = 8'h07;

  // Values after reset
  localparam logic [7:0] CONTROL_A_RST = 8'h10;
  localparam logic [7:0] MAIN_CONTROL_B_RST = 8'h00;
  localparam logic [7:0] REF_CLOCK_POWER_RST = 8'h04;
  localparam logic [7:0] REF_LOCK_SETUP_RST = 8'h00;
  localparam logic [7:0] LOOP_CONTROL_A_RST = 8'h04;
  localparam logic [7:0] LOOP_CONTROL_D_RST = 8'h00;

  // Field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int ACQ_KICK_BIT = 6;
  localparam int BYPASS_BIT = 5;
  localparam int LATCH_MODE_BIT = 4;
  localparam int SIGNAL_LOSS_POWERDOWN_BIT = 3;
  localparam int LOS_POL_BIT = 2;
  localparam int REF_PDN_BIT = 2;
  localparam int LOCK_SRC_BIT = 6;
  localparam int BAND_LSB = 4;
  localparam int DIVIDER_LSB = 0;
  localparam int EDGE_LSB = 3;
  localparam int BW_LSB = 0;
  localparam int ADAPT_SLICE_BIT = 2;
  localparam int SLEW_LSB = 0;
  localparam int MODE_LSB = 4;
  localparam int STICKY_CLR_BIT = 2;
  localparam int STAT_LOS_BIT = 5;
  localparam int STAT_LOL_BIT = 4;
  localparam int STAT_STICKY_BIT = 2;

  // Recovery mode and edge codes
  localparam logic [2:0] MODE_DATA_LOCK = 3'h1;
  localparam logic [2:0] MODE_REF_LOCK = 3'h3;
  localparam logic [1:0] EDGE_RISE_ONLY = 2'h1;
  localparam logic [1:0] EDGE_FALL_ONLY = 2'h2;

  // Bus target address; value is arbitrary
  localparam logic [6:0] DEVICE_ADDR = 7'h2a;

  // One register access from the serial engine
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_type;

endpackage

// [hdl/serial_target.sv]
`timescale 1ns/100ps
// Two-wire target: pointer byte, then writes or reads with auto-increment
module serial_target (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  output cdr_ctrl_pkg::reg_req_type req,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  typedef enum logic [3:0] {
    IDLE = 4'h0, ADDR = 4'h1, ACK_A = 4'h2, PTR = 4'h3, ACK_P = 4'h4,
    WDATA = 4'h5, ACK_W = 4'h6, RDATA = 4'h7, RACK = 4'h8
  } tstate_type;

  tstate_type state_q; // Byte-level position in a transfer
  logic scl_q; // Previous clock line sample
  logic sda_q; // Previous data line sample
  logic [7:0] shift_q; // Byte being received or sent
  logic [3:0] cnt_q; // Bits handled in the current byte
  logic [7:0] ptr_q; // Register pointer
  logic rd_mode_q; // Direction bit of the address byte
  logic rise, fall, start, stop;

  assign rise = scl & ~scl_q;
  assign fall = ~scl & scl_q;
  // Data edges while the clock is high frame a transfer
  assign start = scl & scl_q & sda_q & ~sda_in;
  assign stop = scl & scl_q & ~sda_q & sda_in;
  assign rd_addr = ptr_q;

  // Line history for edge detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // Transfer sequencing; oe pulls the line low
  always_ff @(posedge mclk) begin
    req.wr <= 1'b0;
    if (rst) begin
      state_q <= IDLE;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      rd_mode_q <= 1'b0;
      sda_oe <= 1'b0;
      req.addr <= 8'h00;
      req.data <= 8'h00;
    end else if (start) begin
      state_q <= ADDR;
      cnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop) begin
      state_q <= IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (state_q)
        IDLE: begin
        end
        ADDR, PTR, WDATA: begin
          if (rise) begin
            shift_q <= {shift_q[6:0], sda_in};
            cnt_q <= cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            sda_oe <= 1'b1;
            if (state_q == ADDR) begin
              rd_mode_q <= shift_q[0];
              // Foreign address: stay off the bus
              if (shift_q[7:1] == cdr_ctrl_pkg::DEVICE_ADDR) begin
                state_q <= ACK_A;
              end else begin
                sda_oe <= 1'b0;
                state_q <= IDLE;
              end
            end else if (state_q == PTR) begin
              ptr_q <= shift_q;
              state_q <= ACK_P;
            end else begin
              req.wr <= 1'b1;
              req.addr <= ptr_q;
              req.data <= shift_q;
              state_q <= ACK_W;
            end
          end
        end
        ACK_A: begin
          if (fall) begin
            cnt_q <= 4'h0;
            if (rd_mode_q) begin
              shift_q <= rd_data;
              sda_oe <= ~rd_data[7];
              state_q <= RDATA;
            end else begin
              sda_oe <= 1'b0;
              state_q <= PTR;
            end
          end
        end
        ACK_P, ACK_W: begin
          if (fall) begin
            sda_oe <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= WDATA;
            if (state_q == ACK_W) begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        RDATA: begin
          if (rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (fall) begin
            if (cnt_q == 4'h8) begin
              sda_oe <= 1'b0;
              ptr_q <= ptr_q + 8'h01;
              state_q <= RACK;
            end else begin
              sda_oe <= ~shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
        end
        RACK: begin
          // A not-acknowledge from the host ends the read
          if (rise && sda_in) begin
            state_q <= IDLE;
          end else if (fall) begin
            shift_q <= rd_data;
            sda_oe <= ~rd_data[7];
            cnt_q <= 4'h0;
            state_q <= RDATA;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

endmodule

// [hdl/cdr_control_registers.sv]
`timescale 1ns/100ps
// Contract
// - Write one then zero resets the device
// - Write one then zero starts acquisition
// - Power-down bit disables loss-of-signal detection
// - Polarity bit selects loss-of-signal pin sense
// - Reference clock enabled only when bit cleared
// - Lock check against reference or data
// - Band field selects reference frequency band
// - Ratio field encodes two to N minus one
// - Reference normalised to lowest band by shift
// - Edge field picks rising, falling or both
// - Bandwidth scales by field over four
// - Adaptive bit enables automatic slice threshold
// - Slew field sets delay loop bandwidth
// - Sticky lock-loss flag cleared by writing one
// - Mode field selects data or reference lock
module cdr_control_registers (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic signal_loss_raw,
  input wire logic lock_loss_raw,
  output logic signal_loss_pin,
  output logic lock_loss,
  output logic signal_loss_powerdown,
  output logic soft_reset_pulse,
  output logic acquisition_kick,
  output logic recovery_bypass,
  output logic ref_clock_enable,
  output logic lock_check_vs_data,
  output logic reference_lock_mode,
  output logic data_lock_mode,
  output logic [1:0] ref_band_select,
  output logic [3:0] data_ref_divider,
  output logic [15:0] ratio_times_two,
  output logic edge_rise_en,
  output logic edge_fall_en,
  output logic [2:0] loop_bw_scale,
  output logic adaptive_slice_en,
  output logic [1:0] dll_slew
);

  cdr_ctrl_pkg::reg_req_type req; // Write strobe from the bus engine
  logic [7:0] rd_addr; // Register pointer for reads
  logic [7:0] rd_data; // Read mux result
  logic target_oe; // Engine pull-down request

  logic [7:0] control_a_q; // Recovery mode field
  logic [7:0] main_control_b_q; // Main control bits
  logic [7:0] ref_clock_power_q; // Reference clock power-down
  logic [7:0] ref_lock_setup_q; // Band, ratio and lock source
  logic [7:0] loop_control_a_q; // Edge select and bandwidth
  logic [7:0] loop_control_d_q; // Adaptive slice and slew
  logic sticky_q; // Lock loss seen since last clear
  logic soft_rst_q; // Registered software reset strobe
  logic reg_rst; // Combined reset for the register bank
  logic wr_b, wr_a, clr_sticky;

  serial_target u_target (
    .mclk(mclk),
    .rst(reg_rst),
    .scl(scl),
    .sda_in(sda_in),
    .sda_oe(target_oe),
    .req(req),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Software reset acts one cycle after the falling write
  assign reg_rst = rst | soft_rst_q;
  assign wr_b = req.wr && req.addr == cdr_ctrl_pkg::MAIN_CONTROL_B_OFS;
  assign wr_a = req.wr && req.addr == cdr_ctrl_pkg::CONTROL_A_OFS;
  assign clr_sticky = wr_a && req.data[cdr_ctrl_pkg::STICKY_CLR_BIT];

  // Masked store keeps reserved bits at zero
  function automatic logic [7:0] masked(input logic [7:0] d,
                                        input logic [7:0] m);
    masked = d & m;
  endfunction

  // Write decode; only documented bits are stored
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      control_a_q <= cdr_ctrl_pkg::CONTROL_A_RST;
      main_control_b_q <= cdr_ctrl_pkg::MAIN_CONTROL_B_RST;
      ref_clock_power_q <= cdr_ctrl_pkg::REF_CLOCK_POWER_RST;
      ref_lock_setup_q <= cdr_ctrl_pkg::REF_LOCK_SETUP_RST;
      loop_control_a_q <= cdr_ctrl_pkg::LOOP_CONTROL_A_RST;
      loop_control_d_q <= cdr_ctrl_pkg::LOOP_CONTROL_D_RST;
    end else if (req.wr) begin
      unique case (req.addr)
        cdr_ctrl_pkg::CONTROL_A_OFS:
          control_a_q <= masked(req.data, cdr_ctrl_pkg::CONTROL_A_MASK);
        cdr_ctrl_pkg::MAIN_CONTROL_B_OFS:
          main_control_b_q <= masked(req.data,
                                     cdr_ctrl_pkg::MAIN_CONTROL_B_MASK);
        cdr_ctrl_pkg::REF_CLOCK_POWER_OFS:
          ref_clock_power_q <= masked(req.data,
                                      cdr_ctrl_pkg::REF_CLOCK_POWER_MASK);
        cdr_ctrl_pkg::REF_LOCK_SETUP_OFS:
          ref_lock_setup_q <= masked(req.data,
                                     cdr_ctrl_pkg::REF_LOCK_SETUP_MASK);
        cdr_ctrl_pkg::LOOP_CONTROL_A_OFS:
          loop_control_a_q <= masked(req.data,
                                     cdr_ctrl_pkg::LOOP_CONTROL_A_MASK);
        cdr_ctrl_pkg::LOOP_CONTROL_D_OFS:
          loop_control_d_q <= masked(req.data,
                                     cdr_ctrl_pkg::LOOP_CONTROL_D_MASK);
        default: begin
          // Unmapped pointer: write is dropped
        end
      endcase
    end
  end

  // One-then-zero sequences become single-cycle strobes
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      soft_rst_q <= 1'b0;
      soft_reset_pulse <= 1'b0;
      acquisition_kick <= 1'b0;
    end else begin
      soft_rst_q <= wr_b
        && main_control_b_q[cdr_ctrl_pkg::SOFT_RESET_BIT]
        && !req.data[cdr_ctrl_pkg::SOFT_RESET_BIT];
      soft_reset_pulse <= wr_b
        && main_control_b_q[cdr_ctrl_pkg::SOFT_RESET_BIT]
        && !req.data[cdr_ctrl_pkg::SOFT_RESET_BIT];
      acquisition_kick <= wr_b
        && main_control_b_q[cdr_ctrl_pkg::ACQ_KICK_BIT]
        && !req.data[cdr_ctrl_pkg::ACQ_KICK_BIT];
    end
  end

  // Sticky lock loss; a new event beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      sticky_q <= 1'b0;
    end else if (lock_loss_raw) begin
      sticky_q <= 1'b1;
    end else if (clr_sticky) begin
      sticky_q <= 1'b0;
    end
  end

  // Read mux; unmapped pointers and reserved bits read zero
  always_comb begin
    rd_data = 8'h00;
    unique case (rd_addr)
      cdr_ctrl_pkg::STATUS_A_OFS: begin
        rd_data[cdr_ctrl_pkg::STAT_LOS_BIT] = signal_loss_raw
          & ~main_control_b_q[cdr_ctrl_pkg::SIGNAL_LOSS_POWERDOWN_BIT];
        rd_data[cdr_ctrl_pkg::STAT_LOL_BIT] = lock_loss_raw;
        rd_data[cdr_ctrl_pkg::STAT_STICKY_BIT] = sticky_q;
      end
      cdr_ctrl_pkg::CONTROL_A_OFS: rd_data = control_a_q;
      cdr_ctrl_pkg::MAIN_CONTROL_B_OFS: rd_data = main_control_b_q;
      cdr_ctrl_pkg::REF_CLOCK_POWER_OFS: rd_data = ref_clock_power_q;
      cdr_ctrl_pkg::REF_LOCK_SETUP_OFS: rd_data = ref_lock_setup_q;
      cdr_ctrl_pkg::LOOP_CONTROL_A_OFS: rd_data = loop_control_a_q;
      cdr_ctrl_pkg::LOOP_CONTROL_D_OFS: rd_data = loop_control_d_q;
      default: rd_data = 8'h00;
    endcase
  end

  // Serial line drive; the line is only ever pulled low
  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= target_oe;
    end
  end

  // Loss-of-signal and lock-loss outputs
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      signal_loss_powerdown <= 1'b0;
      signal_loss_pin <= 1'b0;
      lock_loss <= 1'b0;
    end else begin
      signal_loss_powerdown <=
        main_control_b_q[cdr_ctrl_pkg::SIGNAL_LOSS_POWERDOWN_BIT];
      // Powered-down detector reports no loss, then polarity applies
      signal_loss_pin <= (signal_loss_raw
        & ~main_control_b_q[cdr_ctrl_pkg::SIGNAL_LOSS_POWERDOWN_BIT])
        ^ main_control_b_q[cdr_ctrl_pkg::LOS_POL_BIT];
      // Latched mode holds the report until the sticky clear
      lock_loss <= main_control_b_q[cdr_ctrl_pkg::LATCH_MODE_BIT]
        ? (sticky_q | lock_loss_raw) : lock_loss_raw;
    end
  end

  // Recovery path and reference-lock controls
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      recovery_bypass <= 1'b0;
      ref_clock_enable <= 1'b0;
      lock_check_vs_data <= 1'b0;
      reference_lock_mode <= 1'b0;
      data_lock_mode <= 1'b0;
      ref_band_select <= 2'h0;
      data_ref_divider <= 4'h0;
      ratio_times_two <= 16'h0001;
    end else begin
      recovery_bypass <= main_control_b_q[cdr_ctrl_pkg::BYPASS_BIT];
      ref_clock_enable <=
        ~ref_clock_power_q[cdr_ctrl_pkg::REF_PDN_BIT];
      lock_check_vs_data <=
        ref_lock_setup_q[cdr_ctrl_pkg::LOCK_SRC_BIT];
      reference_lock_mode <= control_a_q[cdr_ctrl_pkg::MODE_LSB +: 3]
        == cdr_ctrl_pkg::MODE_REF_LOCK;
      data_lock_mode <= control_a_q[cdr_ctrl_pkg::MODE_LSB +: 3]
        == cdr_ctrl_pkg::MODE_DATA_LOCK;
      // Band code is also the shift that normalises the reference
      ref_band_select <=
        ref_lock_setup_q[cdr_ctrl_pkg::BAND_LSB +: 2];
      data_ref_divider <=
        ref_lock_setup_q[cdr_ctrl_pkg::DIVIDER_LSB +: 4];
      // Ratio in halves avoids a fraction for code zero
      ratio_times_two <= 16'h0001
        << ref_lock_setup_q[cdr_ctrl_pkg::DIVIDER_LSB +: 4];
    end
  end

  // Loop tuning outputs
  always_ff @(posedge mclk) begin
    if (reg_rst) begin
      edge_rise_en <= 1'b1;
      edge_fall_en <= 1'b1;
      loop_bw_scale <= 3'h4;
      adaptive_slice_en <= 1'b0;
      dll_slew <= 2'h0;
    end else begin
      edge_rise_en <= loop_control_a_q[cdr_ctrl_pkg::EDGE_LSB +: 2]
        != cdr_ctrl_pkg::EDGE_FALL_ONLY;
      edge_fall_en <= loop_control_a_q[cdr_ctrl_pkg::EDGE_LSB +: 2]
        != cdr_ctrl_pkg::EDGE_RISE_ONLY;
      loop_bw_scale <= loop_control_a_q[cdr_ctrl_pkg::BW_LSB +: 3];
      adaptive_slice_en <=
        loop_control_d_q[cdr_ctrl_pkg::ADAPT_SLICE_BIT];
      dll_slew <= loop_control_d_q[cdr_ctrl_pkg::SLEW_LSB +: 2];
    end
  end

endmodule

// [verification/cdr_control_monitor.sv]
`timescale 1ns/100ps
// Watches the decoded outputs against their causes at the pins
module cdr_control_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic signal_loss_raw,
  input wire logic lock_loss_raw,
  input wire logic signal_loss_pin,
  input wire logic lock_loss,
  input wire logic signal_loss_powerdown,
  input wire logic soft_reset_pulse,
  input wire logic acquisition_kick,
  input wire logic ref_clock_enable,
  input wire logic reference_lock_mode,
  input wire logic data_lock_mode,
  input wire logic [3:0] data_ref_divider,
  input wire logic [15:0] ratio_times_two,
  input wire logic edge_rise_en,
  input wire logic edge_fall_en,
  input wire logic [2:0] loop_bw_scale
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Decoded view of the register defaults
  sequence defaults_shown;
    loop_bw_scale == 3'h4 && !ref_clock_enable && edge_rise_en && edge_fall_en;
  endsequence
  // Detector input moves while the detector has been powered for two cycles
  sequence los_live_move;
    !signal_loss_powerdown && !$past(signal_loss_powerdown) &&
    $changed(signal_loss_raw);
  endsequence
  // Same move with the detector held powered down
  sequence los_off_move;
    signal_loss_powerdown && $past(signal_loss_powerdown) &&
    $changed(signal_loss_raw);
  endsequence
  a_srst_one_cycle: assert property (
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");
  a_srst_restores: assert property (
    soft_reset_pulse |-> ##[1:3] defaults_shown)
    else $error("soft reset did not restore defaults");
  a_kick_one_cycle: assert property (
    acquisition_kick |=> !acquisition_kick)
    else $error("acquisition kick longer than one cycle");
  a_los_live_follow: assert property (
    los_live_move |=> $changed(signal_loss_pin))
    else $error("loss pin ignored detector while powered");
  a_los_off_quiet: assert property (
    los_off_move |=> $stable(signal_loss_pin))
    else $error("loss pin moved while detector powered down");
  a_reset_defaults: assert property (
    $fell(rst) |-> defaults_shown)
    else $error("outputs not at defaults after reset");
  a_ratio_power: assert property (
    ratio_times_two == (16'h0001 << data_ref_divider))
    else $error("ratio does not match divider code");
  a_edge_some: assert property (edge_rise_en || edge_fall_en)
    else $error("no edge selected for phase detection");
  a_mode_exclusive: assert property (
    !(reference_lock_mode && data_lock_mode))
    else $error("both recovery modes active");
  a_lock_follow: assert property (lock_loss_raw |=> lock_loss)
    else $error("lock loss not reported");
endmodule
bind cdr_control_registers cdr_control_monitor mon (.mclk(mclk), .rst(rst),
  .signal_loss_raw(signal_loss_raw), .lock_loss_raw(lock_loss_raw),
  .signal_loss_pin(signal_loss_pin), .lock_loss(lock_loss),
  .signal_loss_powerdown(signal_loss_powerdown),
  .soft_reset_pulse(soft_reset_pulse), .acquisition_kick(acquisition_kick),
  .ref_clock_enable(ref_clock_enable),
  .reference_lock_mode(reference_lock_mode), .data_lock_mode(data_lock_mode),
  .data_ref_divider(data_ref_divider), .ratio_times_two(ratio_times_two),
  .edge_rise_en(edge_rise_en), .edge_fall_en(edge_fall_en),
  .loop_bw_scale(loop_bw_scale));

// [verification/cdr_host_model.sv]
`timescale 1ns/100ps
// Bus host: drives the clock and pulls data low; a pull-up lifts the line
module cdr_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Cycles per clock phase, above the two-sample floor of the target
  localparam int QTR = 3;
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Lines move on falling mclk, clear of the target's sampling edge
  task automatic hold();
    repeat (QTR) @(negedge mclk);
  endtask
  // Data changes one cycle after clock falls, never while clock is high
  task automatic bit_io(input logic b, output logic r);
    @(negedge mclk);
    sda_low = !b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic start();
    @(negedge mclk);
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
  endtask
  // Stop: data rises while clock is high, bus left idle
  task automatic stop();
    @(negedge mclk);
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask
  // One byte MSB first, acknowledge slot released for the target
  task automatic send(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    send({cdr_ctrl_pkg::DEVICE_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask
  // Pointer write, repeated start, one byte read and refused with NACK
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    send({cdr_ctrl_pkg::DEVICE_ADDR, 1'b0});
    send(a);
    start();
    send({cdr_ctrl_pkg::DEVICE_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop();
  endtask
endmodule

// [verification/cdr_control_registers_tb.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module cdr_control_registers_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic signal_loss_raw = 1'b0;
  logic lock_loss_raw = 1'b0;
  logic scl, sda_low, sda_oe, sda_line, signal_loss_pin, lock_loss;
  logic signal_loss_powerdown, soft_reset_pulse, acquisition_kick;
  logic recovery_bypass, ref_clock_enable, lock_check_vs_data;
  logic reference_lock_mode, data_lock_mode, edge_rise_en, edge_fall_en;
  logic adaptive_slice_en, sda_out;
  logic [1:0] ref_band_select, dll_slew;
  logic [3:0] data_ref_divider;
  logic [15:0] ratio_times_two;
  logic [2:0] loop_bw_scale;
  int fail_count = 0;
  int checks = 0;
  int kick_n = 0;
  int srst_n = 0;
  int c0;
  logic [31:0] seed = 32'h0000_00e8;
  logic [7:0] v, fa;
  // Register map: offset, writable mask, reset value
  logic [7:0] ofs [6] = '{8'h08, 8'h09, 8'h0a, 8'h0f, 8'h10, 8'h13};
  logic [7:0] msk [6] = '{8'h70, 8'hfc, 8'h04, 8'h7f, 8'h1f, 8'h07};
  logic [7:0] rv [6] = '{8'h10, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00};
  // Pull-up line: low when either party pulls
  assign sda_line = !(sda_low || sda_oe);
  always #5 mclk = ~mclk;
  // Pulses are one cycle wide; count them mid-cycle, clear of the launch
  always @(negedge mclk) begin
    if (acquisition_kick === 1'b1) kick_n++;
    if (soft_reset_pulse === 1'b1) srst_n++;
  end
  cdr_host_model host (.mclk(mclk), .sda(sda_line), .scl(scl),
    .sda_low(sda_low));
  cdr_control_registers dut (.mclk(mclk), .rst(rst), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .signal_loss_raw(signal_loss_raw), .lock_loss_raw(lock_loss_raw),
    .signal_loss_pin(signal_loss_pin), .lock_loss(lock_loss),
    .signal_loss_powerdown(signal_loss_powerdown),
    .soft_reset_pulse(soft_reset_pulse), .acquisition_kick(acquisition_kick),
    .recovery_bypass(recovery_bypass), .ref_clock_enable(ref_clock_enable),
    .lock_check_vs_data(lock_check_vs_data),
    .reference_lock_mode(reference_lock_mode),
    .data_lock_mode(data_lock_mode), .ref_band_select(ref_band_select),
    .data_ref_divider(data_ref_divider), .ratio_times_two(ratio_times_two),
    .edge_rise_en(edge_rise_en), .edge_fall_en(edge_fall_en),
    .loop_bw_scale(loop_bw_scale), .adaptive_slice_en(adaptive_slice_en),
    .dll_slew(dll_slew));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Expected pin: gated detector, then the chosen sense
  function automatic logic exp_los(input logic r, pdn, pol);
    return (r & !pdn) ^ pol;
  endfunction
  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Write, then let the one-edge output lag settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    repeat (4) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.read_reg(a, r);
    `CHK(r, e)
  endtask
  // Decoded outputs for a value just written at offset a
  task automatic outs(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h08: begin
        `CHK(reference_lock_mode, d[6:4] == 3'h3)
        `CHK(data_lock_mode, d[6:4] == 3'h1)
      end
      8'h09: begin
        `CHK(signal_loss_powerdown, d[3])
        `CHK(recovery_bypass, d[5])
      end
      8'h0a: `CHK(ref_clock_enable, !d[2])
      8'h0f: begin
        `CHK(lock_check_vs_data, d[6])
        `CHK(ref_band_select, d[5:4])
        `CHK(data_ref_divider, d[3:0])
        `CHK(ratio_times_two, 16'h0001 << d[3:0])
      end
      8'h10: begin
        `CHK(edge_rise_en, d[4:3] != 2'h2)
        `CHK(edge_fall_en, d[4:3] != 2'h1)
        `CHK(loop_bw_scale, d[2:0])
      end
      default: begin
        `CHK(adaptive_slice_en, d[2])
        `CHK(dll_slew, d[1:0])
      end
    endcase
  endtask
  // Cuts a hang short
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    $display("Error at %0t: run too long", $time);
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(ref_clock_enable, 1'b0)
    `CHK(loop_bw_scale, 3'h4)
    `CHK(data_lock_mode, 1'b1)
    for (int i = 0; i < 6; i++) rd(ofs[i], rv[i]);
    rd(8'h0b, 8'h00);
    $display("Test reset values done");
    // Random values, reserved bits set on purpose; kick and reset kept clear
    for (int k = 0; k < 30; k++) begin
      seed = xs(seed);
      v = (k % 6 == 1) ? (seed[7:0] & 8'h3c) : seed[7:0];
      wr(ofs[k % 6], v);
      outs(ofs[k % 6], v);
      rd(ofs[k % 6], v & msk[k % 6]);
    end
    // Ratio codes zero and ten, every edge code, both recovery modes
    for (int k = 0; k < 8; k++) begin
      fa = (k < 2) ? 8'h0f : (k < 6) ? 8'h10 : 8'h08;
      v = (k < 2) ? 8'h0a * k[7:0] : {3'h0, k[1:0], 3'h7};
      if (k >= 6) v = (k == 6) ? 8'h10 : 8'h30;
      wr(fa, v);
      outs(fa, v);
    end
    $display("Test field decode done");
    c0 = kick_n;
    wr(8'h09, 8'h40);
    wr(8'h09, 8'h00);
    `CHK(kick_n - c0, 1)
    $display("Test acquisition kick done");
    for (int c = 0; c < 4; c++) begin
      v = {4'h0, c[1:0], 2'h0};
      wr(8'h09, v);
      for (int r = 0; r < 2; r++) begin
        signal_loss_raw = r[0];
        repeat (3) @(negedge mclk);
        `CHK(signal_loss_pin, exp_los(r[0], v[3], v[2]))
      end
      signal_loss_raw = 1'b0;
    end
    $display("Test loss pin done");
    wr(8'h09, 8'h00);
    lock_loss_raw = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK(lock_loss, 1'b1)
    lock_loss_raw = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(lock_loss, 1'b0)
    rd(8'h06, 8'h04);
    wr(8'h09, 8'h10);
    `CHK(lock_loss, 1'b1)
    wr(8'h08, 8'h14);
    `CHK(lock_loss, 1'b0)
    rd(8'h06, 8'h00);
    $display("Test lock loss done");
    wr(8'h0a, 8'h00);
    `CHK(ref_clock_enable, 1'b1)
    wr(8'h0f, 8'h55);
    c0 = srst_n;
    wr(8'h09, 8'h80);
    wr(8'h09, 8'h00);
    `CHK(srst_n - c0, 1)
    `CHK(sda_out, 1'b0)
    rd(8'h0f, 8'h00);
    rd(8'h0a, 8'h04);
    $display("Test soft reset done");
    report_and_stop();
  end
endmodule
